// file: hw/ctu_top.sv
// Trap sequencing and maskable interrupt disable logic of the CPU.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
// Functional notes
// RULE1: Reset loads the status word with 00000020H, interrupts masked.
// RULE2: Maskable requests acknowledged only while the disable flag is clear.
// RULE3: Mask instruction sets the disable flag, unmask clears it.
// RULE4: Return and system-register load update the flag from the new word.
// RULE5: Non-maskable requests and exceptions ignore the disable flag.
// RULE6: Acknowledging a maskable request sets the disable flag.
// RULE7: A held request is acknowledged once its flag is set and mask clears.
// RULE8: Software trap always taken; saves return PC and status word.
// RULE9: Software trap writes cause code, sets in-progress and disable flags.
// RULE10: Software trap operand is a vector 00H to 1FH.
// RULE11: Vectors 00H-0FH go to 00000040H, 10H-1FH to 00000050H.
// RULE12: Return with in-progress set restores PC and status from trap copies.
// RULE13: Every taken exception sets the in-progress flag.
// RULE14: Opcode bits 10:5 all ones, 26:23 from 7 up, bit 16 low is illegal.
// RULE15: Illegal opcode saves PC and status to debug copies, sets NP, EP, ID.
// RULE16: Illegal opcode then jumps to 00000060H.
// RULE17: Debug return restores PC and status from debug copies.
// RULE18: Debug copies are reachable only between the trap and its return.
// RULE19: Debug trap instruction behaves like the illegal-opcode trap.
// RULE20: Software should avoid the illegal encoding on purpose.
// RULE21: Cause code per vector is a design parameter.
module ctu_top #(
    parameter logic [15:0] CODE_BASE = ctu_pkg::SW_CODE_BASE
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                exec_valid,
    input  wire ctu_pkg::ctu_op_t    exec_op,
    input  wire logic [31:0]         exec_instr,
    input  wire logic [31:0]         exec_next_pc,
    input  wire logic [31:0]         exec_psw_wdata,
    input  wire logic [4:0]          exec_vector,
    input  wire logic                irq_req,
    input  wire logic                irq_src_flag,
    input  wire logic [31:0]         irq_handler,
    input  wire logic                nmi_req,
    input  wire logic [31:0]         nmi_handler,
    output logic                     irq_ack,
    output logic                     nmi_ack,
    output logic                     redirect,
    output logic [31:0]              redirect_pc,
    output logic [31:0]              program_status_word,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr
);
    typedef struct packed {
        logic [31:0] program_status_word;
        logic [31:0] trap_return_pc;
        logic [31:0] trap_return_status;
        logic [31:0] exception_cause_reg;
        logic [31:0] debug_return_pc;
        logic [31:0] debug_saved_status;
        logic        dbg_open;
        logic        redirect;
        logic [31:0] redirect_pc;
        logic        irq_ack;
        logic        nmi_ack;
        logic [31:0] prdata;
        logic        pslverr;
    } ctu_state_t;

    ctu_state_t st_ff;
    ctu_state_t nxt_st;

    function automatic logic ctu_is_illegal(input logic [31:0] ins);
        return ins[10:5] == ctu_pkg::ILL_OPCODE
            && ins[26:23] >= ctu_pkg::ILL_SUB_MIN
            && !ins[16];
    endfunction : ctu_is_illegal

    logic        illegal;
    logic        irq_take;
    logic        acc;
    logic        acc_seen_ff;
    logic        trap_take;
    logic        dbg_take;
    logic        apb_wr;
    logic        id_hw_set;

    assign illegal  = exec_valid && ctu_is_illegal(exec_instr);  // [RULE14]
    // Exceptions win over requests; a request stays pending at the source.
    assign irq_take = irq_req && irq_src_flag && !st_ff.program_status_word[ctu_pkg::ID_BIT]
                      && !nmi_req && !exec_valid;                // [RULE2] [RULE7]
    assign acc      = psel && penable;
    assign trap_take = exec_valid && !illegal && exec_op == ctu_pkg::OP_TRAP;
    assign dbg_take  = illegal || (exec_valid && exec_op == ctu_pkg::OP_DEBUG_EXCEPTION_INSTR);
    // Writes land only at the edge that ends the transfer, when pready is seen.
    assign apb_wr    = acc && acc_seen_ff && pwrite;
    // Hardware setting the mask wins over a software clear in the same cycle.
    assign id_hw_set = dbg_take || trap_take || irq_take
                       || (exec_valid && !illegal && exec_op == ctu_pkg::OP_MASK);

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.redirect = 1'b0;
        nxt_st.irq_ack  = 1'b0;
        nxt_st.nmi_ack  = 1'b0;
        if (dbg_take) begin
            nxt_st.debug_return_pc  = exec_next_pc;                         // [RULE15] [RULE19]
            nxt_st.debug_saved_status = st_ff.program_status_word;
            nxt_st.program_status_word[ctu_pkg::NP_BIT] = 1'b1;
            nxt_st.program_status_word[ctu_pkg::EP_BIT] = 1'b1;                  // [RULE13]
            nxt_st.program_status_word[ctu_pkg::ID_BIT] = 1'b1;
            nxt_st.dbg_open    = 1'b1;                           // [RULE18]
            nxt_st.redirect    = 1'b1;
            nxt_st.redirect_pc = ctu_pkg::DBG_HANDLER;           // [RULE16]
        end else if (exec_valid) begin
            case (exec_op)
                ctu_pkg::OP_MASK: begin
                    nxt_st.program_status_word[ctu_pkg::ID_BIT] = 1'b1;          // [RULE3]
                end
                ctu_pkg::OP_UNMASK: begin
                    nxt_st.program_status_word[ctu_pkg::ID_BIT] = 1'b0;          // [RULE3]
                end
                ctu_pkg::OP_SYSREG_LOAD_INSTR: begin
                    nxt_st.program_status_word = exec_psw_wdata;                 // [RULE4]
                end
                ctu_pkg::OP_IRQ_RETURN_INSTR: begin
                    // Without EP set the return belongs to the interrupt path.
                    if (st_ff.program_status_word[ctu_pkg::EP_BIT]) begin
                        nxt_st.program_status_word         = st_ff.trap_return_status;        // [RULE12] [RULE4]
                        nxt_st.redirect    = 1'b1;
                        nxt_st.redirect_pc = st_ff.trap_return_pc;
                    end
                end
                ctu_pkg::OP_TRAP: begin
                    nxt_st.trap_return_pc  = exec_next_pc;                 // [RULE8] [RULE5]
                    nxt_st.trap_return_status = st_ff.program_status_word;
                    nxt_st.exception_cause_reg   = {st_ff.exception_cause_reg[31:16],
                                    CODE_BASE + {11'h000, exec_vector}}; // [RULE9] [RULE21]
                    nxt_st.program_status_word[ctu_pkg::EP_BIT] = 1'b1;          // [RULE13]
                    nxt_st.program_status_word[ctu_pkg::ID_BIT] = 1'b1;
                    nxt_st.redirect    = 1'b1;
                    nxt_st.redirect_pc = (exec_vector < ctu_pkg::VEC_HI_FIRST)
                                         ? ctu_pkg::SW_HANDLER_LO
                                         : ctu_pkg::SW_HANDLER_HI; // [RULE10] [RULE11]
                end
                ctu_pkg::OP_DEBUG_EXCEPTION_RETURN_INSTR: begin
                    nxt_st.program_status_word         = st_ff.debug_saved_status;            // [RULE17]
                    nxt_st.redirect    = 1'b1;
                    nxt_st.redirect_pc = st_ff.debug_return_pc;
                    nxt_st.dbg_open    = 1'b0;                   // [RULE18]
                end
                default: begin
                end
            endcase
        end else if (nmi_req) begin
            nxt_st.nmi_ack     = 1'b1;                           // [RULE5]
            nxt_st.redirect    = 1'b1;
            nxt_st.redirect_pc = nmi_handler;
        end else if (irq_take) begin
            nxt_st.irq_ack     = 1'b1;
            nxt_st.program_status_word[ctu_pkg::ID_BIT] = 1'b1;                  // [RULE6]
            nxt_st.redirect    = 1'b1;
            nxt_st.redirect_pc = irq_handler;
        end
        // Debug copies are writable over APB only while the trap is open.
        nxt_st.pslverr = 1'b0;
        if (acc) begin
            nxt_st.prdata = 32'h0000_0000;
            case (paddr)
                ctu_pkg::ADDR_STATUS:   nxt_st.prdata = {31'h0000_0000, st_ff.dbg_open};
                ctu_pkg::ADDR_CTRL:     nxt_st.prdata = 32'h0000_0000;
                ctu_pkg::ADDR_TRAP_PC:  nxt_st.prdata = st_ff.trap_return_pc;
                ctu_pkg::ADDR_TRAP_PSW: nxt_st.prdata = st_ff.trap_return_status;
                ctu_pkg::ADDR_CAUSE:    nxt_st.prdata = st_ff.exception_cause_reg;
                ctu_pkg::ADDR_PSW:      nxt_st.prdata = st_ff.program_status_word;
                ctu_pkg::ADDR_DBG_PC: begin
                    if (st_ff.dbg_open) begin
                        nxt_st.prdata = st_ff.debug_return_pc;
                        if (apb_wr && !dbg_take) nxt_st.debug_return_pc = pwdata;
                    end else begin
                        nxt_st.pslverr = 1'b1;                   // [RULE18]
                    end
                end
                ctu_pkg::ADDR_DBG_PSW: begin
                    if (st_ff.dbg_open) begin
                        nxt_st.prdata = st_ff.debug_saved_status;
                        if (apb_wr && !dbg_take) nxt_st.debug_saved_status = pwdata;
                    end else begin
                        nxt_st.pslverr = 1'b1;                   // [RULE18]
                    end
                end
                default: nxt_st.pslverr = 1'b1;
            endcase
            // Writes to the trap copies let a handler adjust its return.
            if (apb_wr && !nxt_st.pslverr) begin
                case (paddr)
                    ctu_pkg::ADDR_CTRL: begin
                        nxt_st.program_status_word[ctu_pkg::ID_BIT] = pwdata[0] || id_hw_set; // [RULE6]
                    end
                    ctu_pkg::ADDR_TRAP_PC:  if (!trap_take) nxt_st.trap_return_pc  = pwdata;
                    ctu_pkg::ADDR_TRAP_PSW: if (!trap_take) nxt_st.trap_return_status = pwdata;
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff     <= '0;
            st_ff.program_status_word <= ctu_pkg::PSW_RESET;                     // [RULE1]
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign irq_ack     = st_ff.irq_ack;
    assign nmi_ack     = st_ff.nmi_ack;
    assign redirect    = st_ff.redirect;
    assign redirect_pc = st_ff.redirect_pc;
    assign program_status_word         = st_ff.program_status_word;
    assign prdata      = st_ff.prdata;
    assign pslverr     = st_ff.pslverr;
    // One wait state: the answer is registered, so ready follows the first access cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) acc_seen_ff <= 1'b0;
        else acc_seen_ff <= acc && !acc_seen_ff;
    end
    assign pready = acc_seen_ff;

    a_irq_masked: assert property ( // [RULE2]
        @(posedge clk) disable iff (!rst_b)
        irq_ack
        |-> !$past(st_ff.program_status_word[ctu_pkg::ID_BIT])
    ) else $error("Maskable request taken while masked.");

    a_irq_sets_id: assert property ( // [RULE6]
        @(posedge clk) disable iff (!rst_b)
        irq_ack
        |-> program_status_word[ctu_pkg::ID_BIT]
    ) else $error("Acknowledge left the mask clear.");

    a_irq_needs_flag: assert property ( // [RULE7]
        @(posedge clk) disable iff (!rst_b)
        irq_ack
        |-> $past(irq_req) && $past(irq_src_flag)
    ) else $error("Acknowledge without a flagged request.");

    a_held_req: assert property ( // [RULE7]
        @(posedge clk) disable iff (!rst_b)
        irq_req && irq_src_flag && !st_ff.program_status_word[ctu_pkg::ID_BIT] && !exec_valid && !nmi_req
        |=> irq_ack
    ) else $error("Pending request not taken once unmasked.");

    a_irq_target: assert property ( // [RULE2]
        @(posedge clk) disable iff (!rst_b)
        irq_ack
        |-> redirect && redirect_pc == $past(irq_handler)
    ) else $error("Maskable request went to the wrong handler.");

    a_nmi_ignores_id: assert property ( // [RULE5]
        @(posedge clk) disable iff (!rst_b)
        nmi_req && !exec_valid
        |=> nmi_ack
    ) else $error("Non-maskable request not taken.");

    a_nmi_target: assert property ( // [RULE5]
        @(posedge clk) disable iff (!rst_b)
        nmi_ack
        |-> redirect && redirect_pc == $past(nmi_handler)
    ) else $error("Non-maskable request went to the wrong handler.");

    a_mask_instr: assert property ( // [RULE3]
        @(posedge clk) disable iff (!rst_b)
        exec_valid && !illegal && exec_op == ctu_pkg::OP_MASK
        |=> program_status_word[ctu_pkg::ID_BIT]
    ) else $error("Mask instruction did not set the flag.");

    a_unmask_instr: assert property ( // [RULE3]
        @(posedge clk) disable iff (!rst_b)
        exec_valid && !illegal && exec_op == ctu_pkg::OP_UNMASK && !apb_wr
        |=> !program_status_word[ctu_pkg::ID_BIT]
    ) else $error("Unmask instruction did not clear the flag.");

    a_sysreg_load_instr_load: assert property ( // [RULE4]
        @(posedge clk) disable iff (!rst_b)
        exec_valid && !illegal && exec_op == ctu_pkg::OP_SYSREG_LOAD_INSTR && !apb_wr
        |=> program_status_word == $past(exec_psw_wdata)
    ) else $error("Loaded status word not taken.");

    a_irq_return_instr_restore: assert property ( // [RULE12]
        @(posedge clk) disable iff (!rst_b)
        exec_valid && !illegal && exec_op == ctu_pkg::OP_IRQ_RETURN_INSTR && program_status_word[ctu_pkg::EP_BIT] && !apb_wr
        |=> program_status_word == $past(st_ff.trap_return_status) && redirect && redirect_pc == $past(st_ff.trap_return_pc)
    ) else $error("Trap return did not restore.");

    a_irq_return_instr_no_ep: assert property ( // [RULE12]
        @(posedge clk) disable iff (!rst_b)
        exec_valid && !illegal && exec_op == ctu_pkg::OP_IRQ_RETURN_INSTR && !program_status_word[ctu_pkg::EP_BIT] && !apb_wr
        |=> !redirect && program_status_word == $past(program_status_word)
    ) else $error("Return outside a trap changed state.");

    a_trap_vec: assert property ( // [RULE11]
        @(posedge clk) disable iff (!rst_b)
        trap_take
        |=> redirect && redirect_pc == ($past(exec_vector[4]) ? ctu_pkg::SW_HANDLER_HI
                                                             : ctu_pkg::SW_HANDLER_LO)
    ) else $error("Software trap went to the wrong handler.");

    a_trap_flags: assert property ( // [RULE9]
        @(posedge clk) disable iff (!rst_b)
        trap_take
        |=> program_status_word[ctu_pkg::EP_BIT] && program_status_word[ctu_pkg::ID_BIT]
    ) else $error("Software trap left a flag clear.");

    a_trap_save: assert property ( // [RULE8]
        @(posedge clk) disable iff (!rst_b)
        trap_take
        |=> st_ff.trap_return_pc == $past(exec_next_pc) && st_ff.trap_return_status == $past(program_status_word)
    ) else $error("Software trap save wrong.");

    a_trap_cause: assert property ( // [RULE9]
        @(posedge clk) disable iff (!rst_b)
        trap_take
        |=> st_ff.exception_cause_reg[15:0] == CODE_BASE + 16'($past(exec_vector))
    ) else $error("Cause code wrong.");

    a_ill_entry: assert property ( // [RULE16]
        @(posedge clk) disable iff (!rst_b)
        illegal
        |=> redirect && redirect_pc == ctu_pkg::DBG_HANDLER
    ) else $error("Illegal opcode went to the wrong handler.");

    a_ill_flags: assert property ( // [RULE15]
        @(posedge clk) disable iff (!rst_b)
        dbg_take
        |=> program_status_word[ctu_pkg::NP_BIT] && program_status_word[ctu_pkg::EP_BIT] && program_status_word[ctu_pkg::ID_BIT] && st_ff.dbg_open
    ) else $error("Debug entry left a flag clear.");

    a_ill_save: assert property ( // [RULE15]
        @(posedge clk) disable iff (!rst_b)
        dbg_take
        |=> st_ff.debug_return_pc == $past(exec_next_pc) && st_ff.debug_saved_status == $past(program_status_word)
    ) else $error("Debug entry save wrong.");

    a_debug_exception_instr_entry: assert property ( // [RULE19]
        @(posedge clk) disable iff (!rst_b)
        exec_valid && exec_op == ctu_pkg::OP_DEBUG_EXCEPTION_INSTR
        |=> redirect && redirect_pc == ctu_pkg::DBG_HANDLER
    ) else $error("Debug trap went to the wrong handler.");

    a_debug_exception_return_instr_rest: assert property ( // [RULE17]
        @(posedge clk) disable iff (!rst_b)
        exec_valid && !illegal && exec_op == ctu_pkg::OP_DEBUG_EXCEPTION_RETURN_INSTR && !apb_wr
        |=> program_status_word == $past(st_ff.debug_saved_status) && redirect_pc == $past(st_ff.debug_return_pc) && !st_ff.dbg_open
    ) else $error("Debug return did not restore.");

    a_dbg_closed: assert property ( // [RULE18]
        @(posedge clk) disable iff (!rst_b)
        acc && !st_ff.dbg_open
        && (paddr == ctu_pkg::ADDR_DBG_PC || paddr == ctu_pkg::ADDR_DBG_PSW)
        |=> pslverr
    ) else $error("Debug copy reachable while closed.");

    a_dbg_no_write: assert property ( // [RULE18]
        @(posedge clk) disable iff (!rst_b)
        apb_wr && !st_ff.dbg_open && !dbg_take
        |=> st_ff.debug_return_pc == $past(st_ff.debug_return_pc) && st_ff.debug_saved_status == $past(st_ff.debug_saved_status)
    ) else $error("Debug copy written while closed.");

    a_ready_wait: assert property (
        @(posedge clk) disable iff (!rst_b)
        pready
        |-> $past(acc)
    ) else $error("Ready without an access cycle.");
endmodule : ctu_top

// file: inc/ctu_pkg.sv
// Package with constants for the trap and interrupt mask unit.
package ctu_pkg;
    localparam logic [31:0] PSW_RESET      = 32'h0000_0020;
    localparam int          ID_BIT         = 5;
    localparam int          EP_BIT         = 6;
    localparam int          NP_BIT         = 7;
    localparam logic [31:0] SW_HANDLER_LO  = 32'h0000_0040;
    localparam logic [31:0] SW_HANDLER_HI  = 32'h0000_0050;
    localparam logic [31:0] DBG_HANDLER    = 32'h0000_0060;
    localparam logic [5:0]  ILL_OPCODE     = 6'h3F;
    localparam logic [3:0]  ILL_SUB_MIN    = 4'h7;
    localparam logic [4:0]  VEC_HI_FIRST   = 5'h10;
    localparam logic [15:0] SW_CODE_BASE   = 16'h0040;
    localparam logic [7:0]  ADDR_STATUS    = 8'h00;
    localparam logic [7:0]  ADDR_CTRL      = 8'h04;
    localparam logic [7:0]  ADDR_TRAP_PC   = 8'h08;
    localparam logic [7:0]  ADDR_TRAP_PSW  = 8'h0C;
    localparam logic [7:0]  ADDR_CAUSE     = 8'h10;
    localparam logic [7:0]  ADDR_DBG_PC    = 8'h14;
    localparam logic [7:0]  ADDR_DBG_PSW   = 8'h18;
    localparam logic [7:0]  ADDR_PSW       = 8'h1C;
    typedef enum logic [3:0] {
        OP_NONE   = 4'h0,
        OP_MASK   = 4'h1,
        OP_UNMASK = 4'h2,
        OP_IRQ_RETURN_INSTR   = 4'h3,
        OP_SYSREG_LOAD_INSTR   = 4'h4,
        OP_TRAP   = 4'h5,
        OP_DEBUG_EXCEPTION_INSTR = 4'h6,
        OP_DEBUG_EXCEPTION_RETURN_INSTR  = 4'h7,
        OP_OTHER  = 4'h8
    } ctu_op_t;
endpackage : ctu_pkg

// file: sim/cpu_trap_and_irq_mask_unit_tb.sv
// Self-checking bench for the trap and interrupt mask unit.
`timescale 1ns/10ps
module cpu_trap_and_irq_mask_unit_tb;
    logic             clk, rst_b, exec_valid, raise, nmi_req, psel, penable, pwrite, er, trp;
    ctu_pkg::ctu_op_t exec_op;
    logic [31:0]      exec_instr, exec_next_pc, exec_psw_wdata, irq_handler, nmi_handler;
    logic [31:0]      pwdata, redirect_pc, program_status_word, prdata, rnd, epsw, sav, rd, npc, tpc, wd, ins;
    logic [4:0]       exec_vector, v;
    logic [7:0]       paddr;
    logic             irq_req, irq_src_flag, irq_ack, nmi_ack, redirect, pready, pslverr;
    int               err_count, checked, acks;

    ctu_top uut (.clk(clk), .rst_b(rst_b), .exec_valid(exec_valid), .exec_op(exec_op),
        .exec_instr(exec_instr), .exec_next_pc(exec_next_pc), .exec_psw_wdata(exec_psw_wdata),
        .exec_vector(exec_vector), .irq_req(irq_req), .irq_src_flag(irq_src_flag),
        .irq_handler(irq_handler), .nmi_req(nmi_req), .nmi_handler(nmi_handler),
        .irq_ack(irq_ack), .nmi_ack(nmi_ack), .redirect(redirect), .redirect_pc(redirect_pc),
        .program_status_word(program_status_word), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ctu_irq_ctrl_model partner (.clk(clk), .rst_b(rst_b), .raise(raise), .irq_ack(irq_ack),
        .irq_req(irq_req), .irq_src_flag(irq_src_flag));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Counted away from the rising edge so the pulse is seen settled.
    always @(negedge clk) if (irq_ack === 1'b1) acks++;

    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    function automatic logic [31:0] hv(input logic [4:0] vec);
        return (vec < ctu_pkg::VEC_HI_FIRST) ? ctu_pkg::SW_HANDLER_LO : ctu_pkg::SW_HANDLER_HI;
    endfunction : hv
    task automatic end_sim();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic ex(input ctu_pkg::ctu_op_t op, input logic [31:0] i, input logic [4:0] vc,
                      input logic r);
        rnd = nx(rnd);
        npc = {rnd[31:2], 2'b00};
        @(posedge clk);
        {exec_valid, exec_op, exec_instr, exec_vector} <= {1'b1, op, i, vc};
        {exec_next_pc, exec_psw_wdata} <= {npc, wd};
        @(posedge clk);
        {exec_valid, exec_op} <= {1'b0, ctu_pkg::OP_NONE};
        #1 chk("redirect", {31'h0, r}, {31'h0, redirect});
    endtask : ex
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // Ready is registered, so its level between edges is what the next edge samples.
        for (n = 0; n < 20; n++) begin
            @(negedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            chk("pready", 32'h1, 32'h0);
            end_sim();
        end
        {rd, er} = {prdata, pslverr};
        @(posedge clk);
        {psel, penable} <= 2'b00;
    endtask : apb

    initial begin
        {exec_valid, raise, nmi_req, psel, penable, pwrite, rst_b} = 7'h00;
        {exec_instr, exec_next_pc, exec_psw_wdata, pwdata, wd} = '0;
        {exec_vector, paddr, acks, err_count, checked} = '0;
        exec_op = ctu_pkg::OP_NONE;
        rnd = 32'h7AF0;
        irq_handler = 32'h0000_0100;
        nmi_handler = 32'h0000_0010;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        #1 chk("psw_reset", ctu_pkg::PSW_RESET, program_status_word);
        ex(ctu_pkg::OP_IRQ_RETURN_INSTR, 32'h0, 5'h00, 1'b0);
        chk("irq_return_instr_no_ep", ctu_pkg::PSW_RESET, program_status_word);
        epsw = ctu_pkg::PSW_RESET;
        for (int i = 0; i < 8; i++) begin
            rnd = nx(rnd);
            v = (i < 4) ? 5'(20'h03E1F >> (i * 5)) : rnd[4:0];
            sav = epsw;
            ex(ctu_pkg::OP_TRAP, 32'h0, v, 1'b1);
            tpc = npc;
            epsw = sav | 32'h0000_0060;
            chk("trap_pc", hv(v), redirect_pc);
            chk("trap_psw", epsw, program_status_word);
            apb(1'b0, ctu_pkg::ADDR_CAUSE, 32'h0);
            chk("cause", {16'h0, ctu_pkg::SW_CODE_BASE + 16'(v)}, {16'h0, rd[15:0]});
            apb(1'b0, ctu_pkg::ADDR_TRAP_PC, 32'h0);
            chk("trap_ret_pc", tpc, rd);
            apb(1'b0, ctu_pkg::ADDR_TRAP_PSW, 32'h0);
            chk("trap_ret_psw", sav, rd);
            ex(ctu_pkg::OP_IRQ_RETURN_INSTR, 32'h0, 5'h00, 1'b1);
            chk("irq_return_instr_pc", tpc, redirect_pc);
            epsw = sav;
            chk("irq_return_instr_psw", epsw, program_status_word);
        end
        apb(1'b0, ctu_pkg::ADDR_PSW, 32'h0);
        chk("psw_read", epsw, rd);
        for (int k = 0; k < 5; k++) begin
            rnd = nx(rnd);
            ins = rnd;
            ins[10:5] = (k == 2) ? 6'h00 : ctu_pkg::ILL_OPCODE;
            ins[16] = (k == 4);
            ins[26:23] = (k == 1) ? 4'hF : (k == 3) ? 4'h6 : ctu_pkg::ILL_SUB_MIN;
            trp = (k < 3);
            apb(1'b0, ctu_pkg::ADDR_DBG_PC, 32'h0);
            chk("dbg_refused", 32'h1, {31'h0, er});
            sav = epsw;
            ex(k == 2 ? ctu_pkg::OP_DEBUG_EXCEPTION_INSTR : ctu_pkg::OP_OTHER, ins, 5'h00, trp);
            if (trp) begin
                tpc = npc;
                epsw = sav | 32'h0000_00E0;
                chk("dbg_pc", ctu_pkg::DBG_HANDLER, redirect_pc);
                chk("dbg_psw", epsw, program_status_word);
                apb(1'b0, ctu_pkg::ADDR_DBG_PC, 32'h0);
                chk("dbg_ret_pc", tpc, rd);
                apb(1'b0, ctu_pkg::ADDR_DBG_PSW, 32'h0);
                chk("dbg_ret_psw", sav, rd);
                apb(1'b0, ctu_pkg::ADDR_STATUS, 32'h0);
                chk("dbg_open", 32'h1, {31'h0, rd[0]});
                rnd = nx(rnd);
                tpc = {rnd[31:2], 2'b00};
                apb(1'b1, ctu_pkg::ADDR_DBG_PC, tpc);
                chk("dbg_wr_err", 32'h0, {31'h0, er});
                ex(ctu_pkg::OP_DEBUG_EXCEPTION_RETURN_INSTR, 32'h0, 5'h00, 1'b1);
                chk("debug_exception_return_instr_pc", tpc, redirect_pc);
                epsw = sav;
            end
            chk("psw_after", epsw, program_status_word);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        apb(1'b1, ctu_pkg::ADDR_CTRL, 32'h0);
        #1 chk("ctrl_id", 32'h0, {31'h0, program_status_word[ctu_pkg::ID_BIT]});
        ex(ctu_pkg::OP_MASK, 32'h0, 5'h00, 1'b0);
        chk("mask_id", 32'h1, {31'h0, program_status_word[ctu_pkg::ID_BIT]});
        @(posedge clk) raise <= 1'b1;
        @(posedge clk) raise <= 1'b0;
        repeat (6) @(posedge clk);
        chk("masked_acks", 32'h0, 32'(acks));
        ex(ctu_pkg::OP_UNMASK, 32'h0, 5'h00, 1'b0);
        chk("unmask_id", 32'h0, {31'h0, program_status_word[ctu_pkg::ID_BIT]});
        for (int n = 0; n < 10 && acks == 0; n++) @(posedge clk);
        #1 chk("held_ack", 32'h1, 32'(acks));
        chk("ack_sets_id", 32'h1, {31'h0, program_status_word[ctu_pkg::ID_BIT]});
        for (int j = 0; j < 2; j++) begin
            rnd = nx(rnd);
            wd = rnd;
            wd[5] = j[0];
            ex(ctu_pkg::OP_SYSREG_LOAD_INSTR, 32'h0, 5'h00, 1'b0);
            chk("sysreg_load_instr_id", 32'(j), {31'h0, program_status_word[ctu_pkg::ID_BIT]});
        end
        @(posedge clk) nmi_req <= 1'b1;
        @(posedge clk) nmi_req <= 1'b0;
        #1 chk("nmi_ack", 32'h1, {31'h0, nmi_ack});
        chk("nmi_pc", nmi_handler, redirect_pc);
        end_sim();
    end
endmodule : cpu_trap_and_irq_mask_unit_tb

// file: sim/ctu_irq_ctrl_model.sv
// Interrupt controller model that holds one maskable request until it is acknowledged.
`timescale 1ns/10ps
module ctu_irq_ctrl_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic raise,
    input  wire logic irq_ack,
    output logic      irq_req,
    output logic      irq_src_flag
);
    logic pend_ff;
    // A masked request must not be lost, so it stays pending until the unit takes it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_ff <= 1'b0;
        end else if (raise) begin
            pend_ff <= 1'b1;
        end else if (irq_ack) begin
            pend_ff <= 1'b0;
        end
    end
    assign irq_req      = pend_ff;
    assign irq_src_flag = pend_ff;
endmodule : ctu_irq_ctrl_model
